/* src/chm_defs.svh */
`ifndef CHM_DEFS_SVH
`define CHM_DEFS_SVH

// Register byte offsets on the APB slave
`define CHM_OFF_ERR_STAT   12'h000
`define CHM_OFF_INT_STAT   12'h004
`define CHM_OFF_INT_EN     12'h008
`define CHM_OFF_CTRL       12'h00C
`define CHM_OFF_WINDOW     12'h010
`define CHM_OFF_TOL        12'h014
`define CHM_OFF_GLITCH     12'h018
`define CHM_OFF_GEN_STAT   12'h01C
`define CHM_OFF_EXP_BASE   12'h020
`define CHM_EXP_PAGE       8'h02

// Status bit map: first bit of each group of four user clocks
`define CHM_POS_OVER       0
`define CHM_POS_UNDER      4
`define CHM_POS_GLITCH     8
`define CHM_POS_STOP       12
`define CHM_MAP_BITS       16

// Control and generator status fields
`define CHM_CTRL_MON_EN    0
`define CHM_CTRL_GEN_RST   1
`define CHM_GEN_IN_LOST    0
`define CHM_GEN_FB_LOST    1

// Timing
`define CHM_CLK_NS         8
`define CHM_STOP_CYCLES    50
`define CHM_WIN_NS         10000
`define CHM_NS_PER_US      1000
`define CHM_WIN_CYC        (`CHM_WIN_NS / `CHM_CLK_NS)
`define CHM_TOL_MHZ        1
`define CHM_EXP_MHZ        10
`define CHM_TOL_CNT        (`CHM_TOL_MHZ * `CHM_WIN_NS / `CHM_NS_PER_US)
`define CHM_EXP_CNT        (`CHM_EXP_MHZ * `CHM_WIN_NS / `CHM_NS_PER_US)

// Reset values
`define CHM_RST_CTRL       2'h1
`define CHM_RST_GLITCH     8'h02

`endif

/* src/chm_pkg.sv */
`include "chm_defs.svh"

package chm_pkg;

  // APB request as driven by the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } chm_apb_req_type;

  // APB answer
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } chm_apb_rsp_type;

  // Per clock findings
  typedef struct packed {
    logic over;
    logic under;
    logic glitch;
    logic stop;
  } chm_flags_type;

  // State of one clock checker
  typedef struct packed {
    logic          sync1;
    logic          sync2;
    logic          prev;
    logic [15:0]   edge_cnt;
    logic [5:0]    quiet;
    logic [7:0]    run;
    chm_flags_type flags;
  } chm_chan_state_type;

  // State of the monitor top
  typedef struct packed {
    chm_apb_rsp_type  rsp;
    logic [15:0]      err;
    logic [15:0]      int_stat;
    logic [15:0]      int_en;
    logic [1:0]       ctrl;
    logic [15:0]      win;
    logic [15:0]      tol;
    logic [7:0]       glitch_min;
    logic [3:0][15:0] expect_cnt;
    logic [15:0]      win_cnt;
    logic             win_end;
    logic             irq;
    logic             gen_rst;
    logic [1:0]       lost;
  } chm_top_state_type;

endpackage

/* src/chm_chan.sv */
`timescale 1ns/1ns
`default_nettype none
`include "chm_defs.svh"

module chm_chan
  import chm_pkg::*;
#(
  parameter int STOP_CYCLES = `CHM_STOP_CYCLES
) (
  input  wire logic          mclk_in,
  input  wire logic          rst_b_in,
  input  wire logic          clk_pin_in,
  input  wire logic          win_end_in,
  input  wire logic          en_in,
  input  wire logic [15:0]   exp_in,
  input  wire logic [15:0]   tol_in,
  input  wire logic [7:0]    glitch_min_in,
  output chm_flags_type      flags_out
);

  chm_chan_state_type s;
  chm_chan_state_type next_s;
  logic               edge_seen;
  logic               rise_seen;
  logic [16:0]        upper;
  logic [16:0]        lower_cnt;

  // Edges only from the second sync stage onward
  assign edge_seen = s.sync2 ^ s.prev;
  assign rise_seen = s.sync2 & ~s.prev;
  assign upper     = {1'b0, exp_in} + {1'b0, tol_in};
  assign lower_cnt = {1'b0, s.edge_cnt} + {1'b0, tol_in};

  // Next state of the checker
  always_comb begin
    next_s              = s;
    next_s.sync1        = clk_pin_in;
    next_s.sync2        = s.sync1;
    next_s.prev         = s.sync2;
    next_s.flags.glitch = 1'b0;
    // Quiet time since last transition, saturating
    if (edge_seen) begin
      next_s.quiet = 6'h00;
    end else if (s.quiet <= 6'(STOP_CYCLES)) begin
      next_s.quiet = s.quiet + 6'h01;
    end
    next_s.flags.stop = next_s.quiet > 6'(STOP_CYCLES);
    // Phase length check; one reference period is the resolution
    if (edge_seen) begin
      next_s.flags.glitch = en_in && (s.run < glitch_min_in);
      next_s.run          = 8'h01;
    end else if (s.run != 8'hFF) begin
      next_s.run = s.run + 8'h01;
    end
    // Edge count over the reference window, compared at its end
    if (win_end_in) begin
      next_s.flags.over  = en_in && ({1'b0, s.edge_cnt} > upper);
      next_s.flags.under = en_in && (lower_cnt < {1'b0, exp_in});
      next_s.edge_cnt    = {15'h0000, rise_seen};
    end else if (s.edge_cnt != 16'hFFFF) begin
      next_s.edge_cnt = s.edge_cnt + {15'h0000, rise_seen};
    end
    if (!en_in) begin
      next_s.flags.over  = 1'b0;
      next_s.flags.under = 1'b0;
    end
  end

  // State register; run starts saturated so the first edge is no glitch
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s     <= '0;
      s.run <= 8'hFF;
    end else begin
      s <= next_s;
    end
  end

  assign flags_out = s.flags;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  AST_STOP_CLEARS: assert property (edge_seen |=> !s.flags.stop)
    else $error("stop flag kept after a clock edge");
  AST_STOP_QUIET: assert property ($rose(s.flags.stop) |-> $past(s.sync2, 40) == s.sync2)
    else $error("stop flag raised while clock was toggling");
  AST_OVER_CMP: assert property (win_end_in && en_in && ({1'b0, s.edge_cnt} > upper)
    |=> s.flags.over ##1 (s.flags.over || $past(win_end_in) || !$past(en_in)))
    else $error("overrun not flagged at window end");
  AST_UNDER_CMP: assert property (win_end_in && en_in && (lower_cnt < {1'b0, exp_in}) |=> s.flags.under)
    else $error("underrun not flagged at window end");
  AST_GLITCH_CMP: assert property (edge_seen && en_in && s.run < glitch_min_in |=> s.flags.glitch)
    else $error("short phase not flagged as glitch");

endmodule
`default_nettype wire

/* src/chm_top.sv */
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "chm_defs.svh"


module chm_top
  import chm_pkg::*;
#(
  parameter int NUM_CLK     = 4,
  parameter int STOP_CYCLES = `CHM_STOP_CYCLES
) (
  input  wire logic               mclk_in,
  input  wire logic               rst_b_in,
  input  wire chm_apb_req_type    apb_in,
  output chm_apb_rsp_type         apb_out,
  input  wire logic [NUM_CLK-1:0] uclk_in,
  input  wire logic               gen_in_clk_in,
  input  wire logic               gen_fb_clk_in,
  output logic                    irq_out,
  output logic                    gen_rst_out,
  output logic                    in_lost_out,
  output logic                    fb_lost_out
);

  localparam int NCHK = NUM_CLK + 2;

  chm_top_state_type   s;
  chm_top_state_type   next_s;
  chm_flags_type       flags [NCHK];
  logic [NCHK-1:0]     pins;
  logic [15:0]         events;
  logic [15:0]         w1c;
  logic                setup;
  logic                access;
  logic                hit;
  logic [31:0]         rd;
  logic                mon_en;

  assign pins   = {gen_fb_clk_in, gen_in_clk_in, uclk_in};
  assign setup  = apb_in.psel && !apb_in.penable;
  assign access = apb_in.psel && apb_in.penable && s.rsp.pready;
  assign mon_en = s.ctrl[`CHM_CTRL_MON_EN];

  // One checker per user clock, plus the generator input and feedback clocks
  for (genvar g = 0; g < NCHK; g++) begin : g_chk
    chm_chan #(
      .STOP_CYCLES   (STOP_CYCLES)
    ) u_chk (
      .mclk_in       (mclk_in),
      .rst_b_in      (rst_b_in),
      .clk_pin_in    (pins[g]),
      .win_end_in    (s.win_end),
      .en_in         ((g < NUM_CLK) && mon_en),
      .exp_in        (s.expect_cnt[g % 4]),
      .tol_in        (s.tol),
      .glitch_min_in (s.glitch_min),
      .flags_out     (flags[g])
    );
  end

  // Read decode; misaligned or unmapped addresses answer with an error
  always_comb begin
    hit = 1'b1;
    rd  = 32'h0000_0000;
    if (apb_in.paddr[1:0] != 2'h0) begin
      hit = 1'b0;
    end else if (apb_in.paddr[11:4] == `CHM_EXP_PAGE) begin
      rd = {16'h0000, s.expect_cnt[apb_in.paddr[3:2]]};
    end else begin
      unique case (apb_in.paddr)
        `CHM_OFF_ERR_STAT: rd = {16'h0000, s.err};
        `CHM_OFF_INT_STAT: rd = {16'h0000, s.int_stat};
        `CHM_OFF_INT_EN:   rd = {16'h0000, s.int_en};
        `CHM_OFF_CTRL:     rd = {30'h0000_0000, s.ctrl};
        `CHM_OFF_WINDOW:   rd = {16'h0000, s.win};
        `CHM_OFF_TOL:      rd = {16'h0000, s.tol};
        `CHM_OFF_GLITCH:   rd = {24'h00_0000, s.glitch_min};
        `CHM_OFF_GEN_STAT: rd = {30'h0000_0000, s.lost};
        default:           hit = 1'b0;
      endcase
    end
  end

  // Next state: bus answer, registers, bit map, interrupts
  always_comb begin
    next_s             = s;
    w1c                = 16'h0000;
    // Answer is prepared in setup, so pready is high in the first access cycle
    next_s.rsp.pready  = setup;
    next_s.rsp.pslverr = setup && !hit;
    next_s.rsp.prdata  = (setup && !apb_in.pwrite && hit) ? rd : 32'h0000_0000;
    // Writes land only at the access edge that samples pready
    if (access && apb_in.pwrite && !s.rsp.pslverr) begin
      if (apb_in.paddr[11:4] == `CHM_EXP_PAGE) begin
        next_s.expect_cnt[apb_in.paddr[3:2]] = apb_in.pwdata[15:0];
      end else begin
        unique case (apb_in.paddr)
          `CHM_OFF_INT_STAT: w1c = apb_in.pwdata[15:0];
          `CHM_OFF_INT_EN:   next_s.int_en = apb_in.pwdata[15:0];
          `CHM_OFF_CTRL:     next_s.ctrl = apb_in.pwdata[1:0];
          `CHM_OFF_WINDOW:   next_s.win = apb_in.pwdata[15:0];
          `CHM_OFF_TOL:      next_s.tol = apb_in.pwdata[15:0];
          `CHM_OFF_GLITCH:   next_s.glitch_min = apb_in.pwdata[7:0];
          default:           w1c = 16'h0000;
        endcase
      end
    end
    // Reference window timer shared by all checkers
    next_s.win_end = 1'b0;
    if (s.win_cnt >= s.win - 16'h0001) begin
      next_s.win_cnt = 16'h0000;
      next_s.win_end = 1'b1;
    end else begin
      next_s.win_cnt = s.win_cnt + 16'h0001;
    end
    // Bit map; overlapping flags are passed as found, not filtered
    for (int i = 0; i < NUM_CLK; i++) begin
      next_s.err[`CHM_POS_OVER + i]  = flags[i].over;
      next_s.err[`CHM_POS_UNDER + i] = flags[i].under;
      next_s.err[`CHM_POS_STOP + i]  = mon_en && flags[i].stop;
      // Glitch bit holds until the next window boundary
      next_s.err[`CHM_POS_GLITCH + i] = mon_en && (flags[i].glitch
        || (s.err[`CHM_POS_GLITCH + i] && !s.win_end));
    end
    // Rising error bits are the events; same layout for all three maps
    events            = next_s.err & ~s.err;
    // Set wins over a simultaneous clear
    next_s.int_stat   = (s.int_stat & ~w1c) | (events & s.int_en);
    next_s.irq        = |(next_s.int_stat & next_s.int_en);
    // Generator reset and its lost clock flags
    next_s.gen_rst    = next_s.ctrl[`CHM_CTRL_GEN_RST];
    next_s.lost[`CHM_GEN_IN_LOST] = flags[NUM_CLK].stop;
    next_s.lost[`CHM_GEN_FB_LOST] = flags[NUM_CLK + 1].stop;
  end

  // State register; generator reset is high during our own reset
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s            <= '0;
      s.ctrl       <= `CHM_RST_CTRL;
      s.win        <= 16'(`CHM_WIN_CYC);
      s.tol        <= 16'(`CHM_TOL_CNT);
      s.glitch_min <= `CHM_RST_GLITCH;
      s.expect_cnt <= {4{16'(`CHM_EXP_CNT)}};
      s.gen_rst    <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign apb_out     = s.rsp;
  assign irq_out     = s.irq;
  assign gen_rst_out = s.gen_rst;
  assign in_lost_out = s.lost[`CHM_GEN_IN_LOST];
  assign fb_lost_out = s.lost[`CHM_GEN_FB_LOST];

  // Checks on the register side
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  AST_PREADY_ONE: assert property (setup |=> s.rsp.pready ##1 !s.rsp.pready || setup)
    else $error("pready not a single access cycle");
  AST_UNMAPPED_ERR: assert property (setup && !hit |=> s.rsp.pslverr && s.rsp.prdata == 32'h0000_0000)
    else $error("unmapped address answered without error");
  AST_INT_LATCH: assert property ((events & s.int_en) != 16'h0000
    |=> ((s.int_stat & $past(events & s.int_en)) == $past(events & s.int_en)))
    else $error("enabled event not latched");
  AST_INT_HOLD: assert property ((s.int_stat != 16'h0000) && !(access && apb_in.pwrite)
    |=> ((s.int_stat & $past(s.int_stat)) == $past(s.int_stat)))
    else $error("interrupt status lost without a clear");
  AST_W1C: assert property (access && apb_in.pwrite && apb_in.paddr == `CHM_OFF_INT_STAT && !s.rsp.pslverr
    && events == 16'h0000 |=> (s.int_stat & $past(apb_in.pwdata[15:0])) == 16'h0000)
    else $error("write one did not clear interrupt status");
  AST_IRQ_LEVEL: assert property (##1 (s.int_stat & s.int_en) != 16'h0000 |-> irq_out)
    else $error("irq low with pending enabled status");
  AST_STOP_MAP: assert property (mon_en && flags[0].stop |=> s.err[`CHM_POS_STOP])
    else $error("stop of clock 0 missing from bit map");
  AST_GEN_RST: assert property (access && apb_in.pwrite && apb_in.paddr == `CHM_OFF_CTRL
    |=> ##1 gen_rst_out == $past(apb_in.pwdata[`CHM_CTRL_GEN_RST], 2))
    else $error("generator reset does not follow control");
  AST_IN_LOST: assert property ($rose(flags[NUM_CLK].stop) |=> in_lost_out ##1 in_lost_out
    || !flags[NUM_CLK].stop)
    else $error("lost input not reported");
  AST_IN_BACK: assert property ($fell(flags[NUM_CLK].stop) |=> !in_lost_out)
    else $error("lost input kept after clock returned");

  COV_IRQ:    cover property ($rose(irq_out));
  COV_OVER:   cover property ($rose(s.err[`CHM_POS_OVER]));
  COV_STOP:   cover property ($rose(s.err[`CHM_POS_STOP]) ##[1:100] $fell(s.err[`CHM_POS_STOP]));
  COV_B2B:    cover property (access ##1 access);

endmodule
`default_nettype wire

/* dv/chm_clk_src.sv */
`timescale 1ns/1ns
`default_nettype none

module chm_clk_src #(
  parameter int HALF_NS = 40
) (
  input  wire logic [5:0] run_in,
  output logic [3:0]      uclk_out,
  output logic            in_clk_out,
  output logic            fb_clk_out
);
  logic       phase;
  logic [3:0] flip;
  logic [5:0] gate;

  // Free oscillator, offset so its edges never meet the reference edges
  initial begin
    phase = 1'b0;
    flip  = 4'h0;
    #3;
    forever #(HALF_NS) phase = ~phase;
  end

  // Run requests take effect only while low, so a start or stop never cuts a phase short
  initial begin
    gate = 6'h3F;
    forever begin
      @(negedge phase);
      gate <= run_in;
    end
  end

  // A stopped clock sits flat low, which is what the monitor must catch
  assign uclk_out   = ({4{phase}} & gate[3:0]) ^ flip;
  assign in_clk_out = phase & gate[4];
  assign fb_clk_out = phase & gate[5];

  // Pulse one reference period wide in mid phase, the shortest resolvable glitch
  task automatic glitch(input int idx);
    @(posedge phase);
    #15 flip[idx] = 1'b1;
    #8 flip[idx] = 1'b0;
  endtask
endmodule

`default_nettype wire

/* dv/test_clock_health_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
`include "chm_defs.svh"

module test_clock_health_monitor;
  import chm_pkg::*;
  typedef struct {
    logic [31:0] mask;
    logic [31:0] val;
    logic        err;
  } chm_note_type;
  localparam int WIN   = 100;
  localparam int EDGES = WIN * `CHM_CLK_NS / 80;
  localparam int TOL   = 2;
  logic            mclk_in;
  logic            rst_b_in;
  chm_apb_req_type apb_in;
  chm_apb_rsp_type apb_out;
  logic [3:0]      uclk;
  logic            in_clk;
  logic            fb_clk;
  logic            irq;
  logic            gen_rst;
  logic            in_lost;
  logic            fb_lost;
  logic [5:0]      run;
  chm_note_type    notes[$];
  chm_note_type    note_now;
  int              err_count;
  int              num_checks;
  int              cyc;
  int              seed;

  // Reference clock
  initial mclk_in = 1'b0;
  always #4 mclk_in = ~mclk_in;

  chm_top #(.NUM_CLK(4), .STOP_CYCLES(`CHM_STOP_CYCLES)) i_dut (
    .mclk_in       (mclk_in),
    .rst_b_in      (rst_b_in),
    .apb_in        (apb_in),
    .apb_out       (apb_out),
    .uclk_in       (uclk),
    .gen_in_clk_in (in_clk),
    .gen_fb_clk_in (fb_clk),
    .irq_out       (irq),
    .gen_rst_out   (gen_rst),
    .in_lost_out   (in_lost),
    .fb_lost_out   (fb_lost)
  );

  chm_clk_src #(.HALF_NS(40)) i_src (
    .run_in     (run),
    .uclk_out   (uclk),
    .in_clk_out (in_clk),
    .fb_clk_out (fb_clk)
  );

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One transfer; an edge passes first so release and next setup never share a step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic [31:0] v, input logic e);
    notes.push_back('{m, v, e});
    @(posedge mclk_in);
    apb_in <= '{1'b1, 1'b0, wr, a, d};
    @(posedge mclk_in);
    apb_in.penable <= 1'b1;
    // Wait ends when pready is seen high; the hang guard ends the run if it never comes
    do begin
      @(posedge mclk_in);
    end while (apb_out.pready !== 1'b1);
    apb_in <= '0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
    apb(1'b0, a, 32'h0, m, v, 1'b0);
  endtask

  // Each answer is matched against the oldest note
  always @(posedge mclk_in) begin
    if (apb_out.pready === 1'b1) begin
      if (notes.size() == 0) begin
        check("spare answer", 32'h0, 32'h1);
      end else begin
        note_now = notes.pop_front();
        check("read data", note_now.val, apb_out.prdata & note_now.mask);
        check("slave error", {31'h0, note_now.err}, {31'h0, apb_out.pslverr});
      end
    end
  end

  // Hang guard, well above the few thousand cycles the tests need
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 8000) begin
      err_count++;
      close_out();
    end
  end

  initial begin
    rst_b_in   = 1'b0;
    apb_in     = '0;
    run        = 6'h3F;
    err_count  = 0;
    num_checks = 0;
    cyc        = 0;
    seed       = $urandom(88856);
    repeat (2) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    rd(`CHM_OFF_CTRL, 32'hFFFFFFFF, 32'h00000001);
    rd(`CHM_OFF_WINDOW, 32'hFFFFFFFF, 32'h000004E2);
    rd(`CHM_OFF_TOL, 32'hFFFFFFFF, 32'h0000000A);
    rd(`CHM_OFF_GLITCH, 32'hFFFFFFFF, 32'h00000002);
    rd(`CHM_OFF_EXP_BASE, 32'hFFFFFFFF, 32'h00000064);
    rd(`CHM_OFF_INT_EN, 32'hFFFFFFFF, 32'h00000000);
    rd(`CHM_OFF_ERR_STAT, 32'hFFFFFFFF, 32'h00000000);
    apb(1'b1, 12'h030, 32'hFFFFFFFF, 32'h0, 32'h0, 1'b1);
    apb(1'b0, 12'h001, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b1);
    $display("test reset done");
    // All clocks share one rate; expected counts put 0 above, 1 below, 2 and 3 inside the tolerance band
    wr(`CHM_OFF_WINDOW, 32'(WIN));
    wr(`CHM_OFF_TOL, 32'(TOL));
    wr(`CHM_OFF_EXP_BASE, 32'(EDGES - TOL - 3));
    wr(`CHM_OFF_EXP_BASE + 12'h004, 32'(EDGES + TOL + 3));
    wr(`CHM_OFF_EXP_BASE + 12'h008, 32'(EDGES));
    wr(`CHM_OFF_EXP_BASE + 12'h00C, 32'(EDGES - 1 + int'($urandom % 3)));
    repeat (1600) @(posedge mclk_in);
    rd(`CHM_OFF_ERR_STAT, 32'h0000FFFF, 32'h00000021);
    $display("test frequency done");
    // Stop clock 3 with only its stop event enabled
    wr(`CHM_OFF_INT_EN, 32'h00008000);
    run[3] <= 1'b0;
    repeat (44) @(posedge mclk_in);
    rd(`CHM_OFF_ERR_STAT, 32'h00008000, 32'h00000000);
    repeat (20) @(posedge mclk_in);
    rd(`CHM_OFF_ERR_STAT, 32'h0000F000, 32'h00008000);
    check("irq set", 32'h1, {31'h0, irq});
    rd(`CHM_OFF_INT_STAT, 32'h0000FFFF, 32'h00008000);
    wr(`CHM_OFF_INT_STAT, 32'h00008000);
    repeat (3) @(posedge mclk_in);
    check("irq cleared", 32'h0, {31'h0, irq});
    run[2] <= 1'b0;
    repeat (70) @(posedge mclk_in);
    check("irq masked", 32'h0, {31'h0, irq});
    rd(`CHM_OFF_ERR_STAT, 32'h0000F000, 32'h0000C000);
    run[3:2] <= 2'b11;
    repeat (20) @(posedge mclk_in);
    rd(`CHM_OFF_ERR_STAT, 32'h0000F000, 32'h00000000);
    $display("test stop done");
    // Glitch latched through the interrupt path, immune to window timing
    wr(`CHM_OFF_INT_EN, 32'h00000400);
    i_src.glitch(2);
    repeat (10) @(posedge mclk_in);
    rd(`CHM_OFF_INT_STAT, 32'h00000400, 32'h00000400);
    wr(`CHM_OFF_INT_STAT, 32'h0000FFFF);
    $display("test glitch done");
    wr(`CHM_OFF_CTRL, 32'h00000000);
    repeat (5) @(posedge mclk_in);
    rd(`CHM_OFF_ERR_STAT, 32'h0000FFFF, 32'h00000000);
    $display("test disable done");
    // Generator held in reset while its input is switched
    wr(`CHM_OFF_CTRL, 32'h00000003);
    repeat (3) @(posedge mclk_in);
    check("gen reset", 32'h1, {31'h0, gen_rst});
    run[4] <= 1'b0;
    repeat (70) @(posedge mclk_in);
    check("input lost", 32'h1, {31'h0, in_lost});
    check("fb kept", 32'h0, {31'h0, fb_lost});
    rd(`CHM_OFF_GEN_STAT, 32'h00000003, 32'h00000001);
    run[4] <= 1'b1;
    repeat (25) @(posedge mclk_in);
    check("input back", 32'h0, {31'h0, in_lost});
    wr(`CHM_OFF_CTRL, 32'h00000001);
    repeat (3) @(posedge mclk_in);
    check("gen released", 32'h0, {31'h0, gen_rst});
    run[5] <= 1'b0;
    repeat (70) @(posedge mclk_in);
    check("fb lost", 32'h1, {31'h0, fb_lost});
    run[5] <= 1'b1;
    $display("test generator done");
    close_out();
  end
endmodule

`default_nettype wire
